// file: rtl/pst_clock_timer.sv
`timescale 1ns/1ps
`include "pst_params.svh"

module pst_clock_timer #(
    parameter int CNT_W = 16
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // Control.
    input wire logic run,
    input wire logic [CNT_W-1:0] period_reload,
    input wire logic [CNT_W-1:0] compare_value,
    // Results.
    output logic compare_reference,
    output logic rise_pulse
);

    logic [CNT_W-1:0] count;

    // Edge-aligned PWM: up count 0..period_reload, high while count < compare.
    always_ff @(posedge sys_clk) begin
        if (reset || !run) begin
            count <= '0;
        end else if (count >= period_reload) begin
            count <= '0; // RL1
        end else begin
            count <= count + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset || !run) begin
            compare_reference <= 1'b0;
            rise_pulse <= 1'b0;
        end else begin
            compare_reference <= (count < compare_value); // RL2 RL3
            rise_pulse <= (count == '0) && (compare_value != '0); // RL7
        end
    end

endmodule

// file: rtl/pst_params.svh
`ifndef PST_PARAMS_SVH
`define PST_PARAMS_SVH

// Register indices on the plain register port.
`define REG_CONTROL      4'h0
`define REG_PERIOD       4'h1
`define REG_COMPARE      4'h2
`define REG_START_ADDR   4'h3
`define REG_BUFF_SIZE    4'h4
`define REG_COUNT        4'h5
`define REG_FRAME_LEN    4'h6
`define REG_STATUS       4'h7
`define REG_MEM_ADDR     4'h8
`define REG_MEM_DATA     4'h9

// Control register fields.
`define CTL_GO           0
`define CTL_BYTE_MODE    1
`define CTL_UPPER_BYTE   2
`define CTL_WIDE_SRC     3
`define CTL_CIRCULAR     4
`define CTL_DOUBLE_BUF   5
`define CTL_FRAME_TIMER  6

// Status register fields.
`define STS_BUSY         0
`define STS_DONE         1
`define STS_ACTIVE_PTR   2

`define RESET_PERIOD     16'h0003
`define RESET_COMPARE    16'h0002
`define BYTE_LANES       2'h3

`endif

// file: rtl/pst_pkg.sv
package pst_pkg;

    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic write;
        logic read;
    } reg_req_t;

    typedef struct packed {
        logic go;
        logic byte_mode;
        logic upper_byte;
        logic wide_src;
        logic circular;
        logic double_buf;
        logic frame_timer;
    } ctrl_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_STOP = 2'b10
    } tx_state_t;

endpackage

// file: rtl/pst_transmitter.sv
// Function
// (RL1) Data clock frequency is timer rate over period reload plus one.
// (RL2) Clock high fraction is compare value over period reload plus one.
// (RL3) Clock comes from one edge-aligned PWM channel driven onto a pin.
// (RL4) Output port is 16 bits wide; frame split into words.
// (RL5) Byte option drives only the upper or only the lower port byte.
// (RL6) Each rising data clock edge requests one word move to the port.
// (RL7) The request comes from the channel's compare reference signal.
// (RL8) Mover reads memory and writes the port register.
// (RL9) With 32-bit source and byte port, each word gives four byte writes.
// (RL10) Short frames are counted by the 16-bit transfer counter only.
// (RL11) Long frames are counted by an extra 32-bit frame counter.
// (RL12) Without double buffering, one circular buffer alternates two halves.
// (RL13) Double-buffer mode forces circular operation whatever the wrap bit.
// (RL14) Double-buffer mode holds two pointers, swapped at each buffer end.
// (RL15) Each pointer advances by two buffer sizes after its buffer is sent.
// (RL16) Pointer swapping is direction neutral.
// (RL17) The receiver must know the clock rate; it never learns frame length.
// (RL18) Clock activity delimits the frame.
// (RL19) Last word raises transfer complete and stops the clock at once.
// (RL20) Frame counter counts clock cycles up to the preset length, then stops.
// (RL21) Each port word holds until the next request writes another.
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "pst_params.svh"

module pst_transmitter
    import pst_pkg::*;
#(
    parameter int MEM_AW = 8,
    parameter int CNT_W = 16
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // Register port.
    input wire pst_pkg::reg_req_t bus_req,
    output logic [31:0] rdata,
    // Parallel link.
    output logic clock_out_channel,
    output logic [15:0] data_port,
    // Events.
    output logic transfer_done
);
    import pst_pkg::*;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    ctrl_t ctrl;
    logic [CNT_W-1:0] period_reload;
    logic [CNT_W-1:0] compare_value;
    logic [MEM_AW-1:0] start_addr;
    logic [MEM_AW-1:0] buff_size;
    logic [15:0] transfer_count;
    logic [31:0] frame_len;
    logic [MEM_AW-1:0] mem_wr_addr;
    tx_state_t state;
    logic [15:0] words_left;
    logic [31:0] frame_count;
    logic [MEM_AW-1:0] ptr [0:1];
    logic active_ptr;
    logic [MEM_AW-1:0] offset;
    logic [1:0] lane;
    logic fetch_pending;
    logic [31:0] mem_rd_data;
    logic compare_reference;
    logic request;
    logic wrap_on;
    logic last_word;
    logic frame_end;

    // Without a wide source each memory word carries a single byte in its low lane.
    function automatic logic [7:0] pick_lane(input logic [31:0] w, input logic [1:0] l, input logic wide);
        return wide ? w[8*l +: 8] : w[7:0];
    endfunction

    wire bus_write = bus_req.write;
    wire [3:0] bus_addr = bus_req.addr;
    wire [31:0] bus_wdata = bus_req.wdata;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ctrl <= '0;
            period_reload <= `RESET_PERIOD;
            compare_value <= `RESET_COMPARE;
            start_addr <= '0;
            buff_size <= '0;
            transfer_count <= '0;
            frame_len <= '0;
        end else begin
            if (bus_write) begin
                case (bus_addr)
                    `REG_CONTROL: begin
                        ctrl.go <= bus_wdata[`CTL_GO];
                        ctrl.byte_mode <= bus_wdata[`CTL_BYTE_MODE];
                        ctrl.upper_byte <= bus_wdata[`CTL_UPPER_BYTE];
                        ctrl.wide_src <= bus_wdata[`CTL_WIDE_SRC];
                        ctrl.circular <= bus_wdata[`CTL_CIRCULAR];
                        ctrl.double_buf <= bus_wdata[`CTL_DOUBLE_BUF];
                        ctrl.frame_timer <= bus_wdata[`CTL_FRAME_TIMER];
                    end
                    `REG_PERIOD: period_reload <= bus_wdata[CNT_W-1:0];
                    `REG_COMPARE: compare_value <= bus_wdata[CNT_W-1:0];
                    `REG_START_ADDR: start_addr <= bus_wdata[MEM_AW-1:0];
                    `REG_BUFF_SIZE: buff_size <= bus_wdata[MEM_AW-1:0];
                    `REG_COUNT: transfer_count <= bus_wdata[15:0];
                    `REG_FRAME_LEN: frame_len <= bus_wdata;
                    default: begin
                    end
                endcase
            end
            // Only a control write may decide the start bit at frame end; other writes must not keep it armed.
            if (frame_end && !(bus_write && bus_addr == `REG_CONTROL)) begin
                ctrl.go <= 1'b0; // RL19
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            mem_wr_addr <= '0;
        end else if (bus_write && bus_addr == `REG_MEM_ADDR) begin
            mem_wr_addr <= bus_wdata[MEM_AW-1:0];
        end else if (bus_write && bus_addr == `REG_MEM_DATA) begin
            mem_wr_addr <= mem_wr_addr + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Clock generator and request
    // ------------------------------------------------------------
    pst_clock_timer #(.CNT_W(CNT_W)) clock_timer (
        .sys_clk(sys_clk),
        .reset(reset),
        .run(state == ST_RUN),
        .period_reload(period_reload),
        .compare_value(compare_value),
        .compare_reference(compare_reference),
        .rise_pulse(request)
    );

    // ------------------------------------------------------------
    // Source memory, read one cycle ahead of the request
    // ------------------------------------------------------------
    // The address is formed a cycle ahead so the word sits in the read register before its request.
    wire [MEM_AW-1:0] rd_addr = ptr[active_ptr] + offset;

    pst_word_mem #(.ADDR_W(MEM_AW), .DATA_W(32)) source_mem (
        .sys_clk(sys_clk),
        .wr_en(bus_write && bus_addr == `REG_MEM_DATA),
        .wr_addr(mem_wr_addr),
        .wr_data(bus_wdata),
        .rd_addr(rd_addr),
        .rd_data(mem_rd_data)
    );

    assign wrap_on = ctrl.circular || ctrl.double_buf; // RL13
    assign last_word = ctrl.frame_timer ? (frame_count + 32'h1 >= frame_len) : (words_left == 16'h1);
    assign frame_end = (state == ST_RUN) && request && last_word;

    // ------------------------------------------------------------
    // Transfer state
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: if (ctrl.go) state <= ST_RUN; // RL18
                ST_RUN: if (frame_end) state <= ST_STOP; // RL19 RL20
                ST_STOP: if (!ctrl.go) state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset || state == ST_IDLE) begin
            words_left <= transfer_count; // RL10
            frame_count <= '0; // RL11
            ptr[0] <= start_addr;
            ptr[1] <= start_addr + buff_size; // RL15
            active_ptr <= 1'b0;
            offset <= '0;
            lane <= '0;
        end else if (state == ST_RUN && request) begin // RL6 RL8
            frame_count <= frame_count + 32'h1; // RL20
            if (!ctrl.frame_timer) begin
                words_left <= words_left - 16'h1;
            end
            if (ctrl.byte_mode && ctrl.wide_src && lane != `BYTE_LANES) begin
                lane <= lane + 2'h1; // RL9
            end else begin
                lane <= '0;
                // In double-buffer mode a finished pointer jumps past its partner's buffer, so the source range is walked in order.
                if (wrap_on && offset + 1'b1 == buff_size) begin
                    offset <= '0;
                    active_ptr <= !active_ptr; // RL12 RL14 RL16
                    if (ctrl.double_buf) begin
                        ptr[active_ptr] <= ptr[active_ptr] + buff_size + buff_size; // RL15
                    end
                end else begin
                    offset <= offset + 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            data_port <= '0;
        end else if (state == ST_RUN && request) begin // RL21
            if (!ctrl.byte_mode) begin
                data_port <= mem_rd_data[15:0]; // RL4
            end else if (ctrl.upper_byte) begin
                data_port <= {pick_lane(mem_rd_data, lane, ctrl.wide_src), data_port[7:0]}; // RL5
            end else begin
                data_port <= {data_port[15:8], pick_lane(mem_rd_data, lane, ctrl.wide_src)}; // RL5
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            clock_out_channel <= 1'b0;
            transfer_done <= 1'b0;
            fetch_pending <= 1'b0;
        end else begin
            clock_out_channel <= compare_reference; // RL3
            transfer_done <= frame_end; // RL19
            fetch_pending <= request;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rdata <= '0;
        end else if (bus_req.read) begin
            case (bus_addr)
                `REG_PERIOD: rdata <= {{(32-CNT_W){1'b0}}, period_reload};
                `REG_COMPARE: rdata <= {{(32-CNT_W){1'b0}}, compare_value};
                `REG_COUNT: rdata <= {16'h0000, words_left};
                `REG_FRAME_LEN: rdata <= frame_count;
                `REG_STATUS: rdata <= {29'h0, active_ptr, state == ST_STOP, state == ST_RUN};
                default: rdata <= '0;
            endcase
        end else begin
            rdata <= '0;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_port_stable: assert property (@(posedge sys_clk) disable iff (reset) // RL21
        !$past(request) |-> $stable(data_port)) else $error("port changed without request");

    a_done_stops: assert property (@(posedge sys_clk) disable iff (reset) // RL19
        transfer_done |-> state == ST_STOP) else $error("clock still runs after done");

    a_double_wrap: assert property (@(posedge sys_clk) disable iff (reset) // RL13 RL14
        state == ST_RUN && request && ctrl.double_buf && !ctrl.byte_mode && offset + 1'b1 == buff_size
        |=> offset == '0 && active_ptr != $past(active_ptr))
        else $error("double buffer did not wrap");

    a_idle_quiet: assert property (@(posedge sys_clk) disable iff (reset) // RL18
        state == ST_IDLE ##1 state == ST_IDLE |-> !request) else $error("request outside frame");

    // ------------------------------------------------------------
    // Frame checks
    // ------------------------------------------------------------
    a_request_ref: assert property (@(posedge sys_clk) disable iff (reset) // RL7
        request |-> compare_reference) else $error("request without compare reference high");

    a_port_follows: assert property (@(posedge sys_clk) disable iff (reset) // RL6 RL8
        fetch_pending && $past(state == ST_RUN) && !ctrl.byte_mode |-> data_port == $past(mem_rd_data[15:0]))
        else $error("port word differs from fetched word");

    a_lane_order: assert property (@(posedge sys_clk) disable iff (reset) // RL9
        state == ST_RUN && request && ctrl.byte_mode && ctrl.wide_src && lane != `BYTE_LANES
        |=> lane == $past(lane) + 2'h1 && offset == $past(offset)) else $error("byte lane order broken");

    a_words_count: assert property (@(posedge sys_clk) disable iff (reset) // RL10
        state == ST_RUN && request && !ctrl.frame_timer |=> words_left == $past(words_left) - 16'h1)
        else $error("transfer count did not step");

    a_frame_count: assert property (@(posedge sys_clk) disable iff (reset) // RL20
        state == ST_RUN && request |=> frame_count == $past(frame_count) + 32'h1)
        else $error("frame counter did not step");

    a_pointer_step: assert property (@(posedge sys_clk) disable iff (reset) // RL15
        state == ST_RUN && request && ctrl.double_buf && !ctrl.byte_mode && !active_ptr
        && offset + 1'b1 == buff_size |=> ptr[0] == $past(ptr[0]) + $past(buff_size) + $past(buff_size))
        else $error("first pointer did not advance");

    // The pin register lags the compare reference, so the line settles low two cycles after the done pulse.
    a_clock_stops: assert property (@(posedge sys_clk) disable iff (reset) // RL19
        transfer_done |-> ##2 !clock_out_channel) else $error("clock still toggles after frame end");

    a_go_clears: assert property (@(posedge sys_clk) disable iff (reset) // RL19
        transfer_done && !$past(bus_write && bus_addr == `REG_CONTROL) |-> !ctrl.go)
        else $error("start bit left set after frame end");

endmodule

// file: rtl/pst_word_mem.sv
`timescale 1ns/1ps

module pst_word_mem #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 32
) (
    // Clock.
    input wire logic sys_clk,
    // Write side.
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [DATA_W-1:0] wr_data,
    // Registered read side.
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [DATA_W-1:0] rd_data
);

    logic [DATA_W-1:0] store [0:(1<<ADDR_W)-1];

    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            store[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        rd_data <= store[rd_addr];
    end

endmodule

// file: testbench/pst_receiver_model.sv
`timescale 1ns/1ps

module pst_receiver_model (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // Parallel link.
    input wire logic clock_out_channel,
    input wire logic [15:0] data_port,
    // Observations.
    output logic word_valid,
    output logic [15:0] word,
    output logic edge_valid,
    output logic [15:0] period_seen,
    output logic [15:0] high_seen
);
    logic last_clk;
    logic in_frame;
    logic [15:0] since_rise;
    logic [15:0] high_cnt;
    logic [7:0] idle_cnt;

    // The receiver never learns the frame length, so a long quiet clock is its only end marker.
    always_ff @(posedge sys_clk) begin
        word_valid <= 1'b0;
        edge_valid <= 1'b0;
        if (reset) begin
            last_clk <= 1'b0;
            in_frame <= 1'b0;
            idle_cnt <= 8'h00;
        end else begin
            last_clk <= clock_out_channel;
            since_rise <= since_rise + 16'h0001;
            idle_cnt <= clock_out_channel ? 8'h00 : idle_cnt + 8'h01;
            if (idle_cnt == 8'h28) begin
                in_frame <= 1'b0;
            end
            if (clock_out_channel) begin
                high_cnt <= high_cnt + 16'h0001;
            end
            if (clock_out_channel && !last_clk) begin
                since_rise <= 16'h0001;
                high_cnt <= 16'h0001;
                edge_valid <= in_frame;
                period_seen <= since_rise;
                high_seen <= high_cnt;
                in_frame <= 1'b1;
            end
            if (!clock_out_channel && last_clk) begin
                word_valid <= 1'b1;
                word <= data_port;
            end
        end
    end
endmodule

// file: testbench/tb_top.sv
`timescale 1ns/1ps
`include "pst_params.svh"

module tb_top;
    import pst_pkg::*;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    reg_req_t bus_req = '0;
    logic [31:0] rdata;
    logic clock_out_channel;
    logic [15:0] data_port;
    logic transfer_done;
    logic word_valid;
    logic edge_valid;
    logic [15:0] word;
    logic [15:0] period_seen;
    logic [15:0] high_seen;
    int fails = 0;
    int num_checks = 0;
    int done_count = 0;
    logic [15:0] exp_q[$];
    logic [15:0] exp_mask = 16'hFFFF;
    logic [15:0] exp_period = 16'h0000;
    logic [15:0] exp_high = 16'h0000;
    logic [31:0] rd;

    always #10 sys_clk = ~sys_clk;

    pst_transmitter dut_u (.sys_clk(sys_clk), .reset(reset), .bus_req(bus_req), .rdata(rdata),
        .clock_out_channel(clock_out_channel), .data_port(data_port), .transfer_done(transfer_done));

    pst_receiver_model rx_u (.sys_clk(sys_clk), .reset(reset), .clock_out_channel(clock_out_channel),
        .data_port(data_port), .word_valid(word_valid), .word(word), .edge_valid(edge_valid),
        .period_seen(period_seen), .high_seen(high_seen));

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
        @(posedge sys_clk);
        bus_req <= '0;
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: 32'h0, write: 1'b0, read: 1'b1};
        @(posedge sys_clk);
        bus_req <= '0;
        #1 d = rdata;
    endtask

    // ------------------------------------------------------------
    // Receiver-side comparison of every sampled word and of each clock cycle that a later rising edge in the frame closes.
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (transfer_done === 1'b1) done_count++;
        if (word_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("extra word", 32'h0, 32'h1);
            end else begin
                check("port word", {16'h0, exp_q[0] & exp_mask}, {16'h0, word & exp_mask});
                void'(exp_q.pop_front());
            end
        end
        if (edge_valid === 1'b1) begin
            check("clock period", {16'h0, exp_period}, {16'h0, period_seen});
            check("clock high time", {16'h0, exp_high}, {16'h0, high_seen});
        end
    end

    task automatic run_frame(input logic [31:0] ctl, input logic [15:0] per, input logic [15:0] cmp,
                             input int n_mem, input logic [31:0] count, input logic [31:0] flen);
        logic [31:0] d;
        logic [7:0] b;
        int base;
        int waited;
        exp_period = per + 16'h0001;
        exp_high = cmp;
        exp_mask = !ctl[`CTL_BYTE_MODE] ? 16'hFFFF : ctl[`CTL_UPPER_BYTE] ? 16'hFF00 : 16'h00FF;
        reg_write(`REG_MEM_ADDR, 32'h10);
        reg_write(`REG_START_ADDR, 32'h10);
        reg_write(`REG_BUFF_SIZE, 32'h2);
        for (int i = 0; i < n_mem; i++) begin
            d = $urandom();
            reg_write(`REG_MEM_DATA, d);
            for (int k = 0; k < 4; k++) begin
                b = d[8*k+:8];
                if (!ctl[`CTL_BYTE_MODE]) begin
                    if (k == 0) exp_q.push_back(d[15:0]);
                end else if (k == 0 || ctl[`CTL_WIDE_SRC]) begin
                    exp_q.push_back({b, b});
                end
            end
        end
        if (ctl[`CTL_CIRCULAR] && !ctl[`CTL_DOUBLE_BUF]) begin
            for (int i = 0; i < n_mem; i++) exp_q.push_back(exp_q[i]);
        end
        reg_write(`REG_PERIOD, {16'h0, per});
        reg_write(`REG_COMPARE, {16'h0, cmp});
        reg_write(`REG_COUNT, count);
        reg_write(`REG_FRAME_LEN, flen);
        base = done_count;
        reg_write(`REG_CONTROL, ctl | (32'h1 << `CTL_GO));
        waited = 0;
        while (done_count == base && waited < 3000) begin
            @(posedge sys_clk);
            waited++;
        end
        if (done_count == base) begin
            check("frame end", 32'h1, 32'h0);
            finish_test();
        end
        repeat (60) @(posedge sys_clk);
        check("done pulses", base + 1, done_count);
        check("clock idle", 32'h0, {31'h0, clock_out_channel});
        check("words left", 32'h0, exp_q.size());
        reg_read(`REG_STATUS, rd);
        check("busy", 32'h0, {31'h0, rd[`STS_BUSY]});
    endtask

    initial begin
        void'($urandom(32'h677A));
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        #1;
        check("idle port", 32'h0, {15'h0, clock_out_channel, data_port});
        reg_read(`REG_PERIOD, rd);
        check("period reset", {16'h0, `RESET_PERIOD}, rd);
        reg_read(`REG_COMPARE, rd);
        check("compare reset", {16'h0, `RESET_COMPARE}, rd);
        reg_read(4'hC, rd);
        check("unmapped read", 32'h0, rd);
        reg_read(`REG_COUNT, rd);
        check("count reset", 32'h0, rd);
        run_frame(32'h0, 16'h0003, 16'h0002, 5, 32'h5, 32'h0);
        run_frame(32'h1 << `CTL_BYTE_MODE, 16'h0005, 16'h0003, 4, 32'h4, 32'h0);
        run_frame(32'h6, 16'h0004, 16'h0002, 3, 32'h3, 32'h0);
        run_frame(32'hA, 16'h0003, 16'h0003, 2, 32'h8, 32'h0);
        run_frame(32'h1 << `CTL_FRAME_TIMER, 16'h0003, 16'h0002, 6, 32'h100, 32'h6);
        run_frame(32'h1 << `CTL_CIRCULAR, 16'h0003, 16'h0001, 4, 32'h8, 32'h0);
        run_frame(32'h1 << `CTL_DOUBLE_BUF, 16'h0004, 16'h0003, 6, 32'h6, 32'h0);
        finish_test();
    end
endmodule
